// File: hdl/rsem_monitor.sv
// Operation
// - 16-bit B1 counter counts each B1 error.
// - B1 upper-byte write snapshots and clears counter.
// - B1 counter byte access, upper byte higher.
// - Access bit selects processor or comparator stepping.
// - Pointer reset bit rising edge rewinds pointer.
// - Processor access steps pointer after each access.
// - Set window spans eight times value plus one.
// - Clear window spans eight times value plus one.
// - Errored window: count reaches minimum; zero always.
// - Status sets after run of errored windows.
// - Clean window: count not above maximum; zero always.
// - Status clears after run of clean windows.
// - 13-bit B2 block counter counts block errors.
// - B2 upper-byte write snapshots and clears counter.
// - Trace control bits write-only, reset zero.
// - Config bit selects B1 bit or block counting.
//
// Register bank with byte-wide port; read data appear one cycle after the strobe.
// Assumes framed receive stream supplies error events and frame pulses on sys_clk_i.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "rsem_regs.svh"

module rsem_monitor
  import rsem_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Register port.
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Receive stream events.
  input wire logic frame_pulse_i,
  input wire logic b1_bit_err_i,
  input wire logic [3:0] b1_bit_err_cnt_i,
  input wire logic b1_blk_err_i,
  input wire logic b2_blk_err_i,
  input wire logic trace_step_i,
  // Results.
  output logic [7:0] trace_string_byte_o,
  output logic excessive_mux_error_status_o,
  output logic irq_o
);

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  logic wr_ctrl, wr_data, rd_data, wr_b1hi, wr_b2hi;
  assign wr_ctrl = reg_wr_i && (reg_addr_i == `RSEM_TRACE_CTRL);
  assign wr_data = reg_wr_i && (reg_addr_i == `RSEM_TRACE_DATA);
  assign rd_data = reg_rd_i && (reg_addr_i == `RSEM_TRACE_DATA);
  assign wr_b1hi = reg_wr_i && (reg_addr_i == `RSEM_B1_HI);
  assign wr_b2hi = reg_wr_i && (reg_addr_i == `RSEM_B2BLK_HI);

  logic [10:0] set_window_length_q, clear_window_length_q;
  logic [6:0] set_window_run_q, clear_window_run_q;
  logic [7:0] errored_window_threshold_q, clean_window_threshold_q;
  logic parity_count_unit_select_q;
  logic trace_processor_access_q, trace_pointer_reset_q;
  logic [2:0] int_en_q;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      set_window_length_q <= 11'h000;
      clear_window_length_q <= 11'h000;
      set_window_run_q <= `RSEM_SETRUN_RST;
      clear_window_run_q <= `RSEM_CLRRUN_RST;
      errored_window_threshold_q <= `RSEM_ERRMIN_RST;
      clean_window_threshold_q <= `RSEM_CLEANMAX_RST;
      parity_count_unit_select_q <= 1'b0;
      trace_processor_access_q <= 1'b0;
      trace_pointer_reset_q <= 1'b0;
      int_en_q <= 3'h0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `RSEM_SETWIN_LO: set_window_length_q[7:0] <= reg_wdata_i;
        `RSEM_SETWIN_HI: set_window_length_q[10:8] <= reg_wdata_i[2:0];
        `RSEM_CLRWIN_LO: clear_window_length_q[7:0] <= reg_wdata_i;
        `RSEM_CLRWIN_HI: clear_window_length_q[10:8] <= reg_wdata_i[2:0];
        `RSEM_SETRUN: set_window_run_q <= reg_wdata_i[6:0];
        `RSEM_CLRRUN: clear_window_run_q <= reg_wdata_i[6:0];
        `RSEM_ERRMIN: errored_window_threshold_q <= reg_wdata_i;
        `RSEM_CLEANMAX: clean_window_threshold_q <= reg_wdata_i;
        `RSEM_B1_CFG: parity_count_unit_select_q <= reg_wdata_i[0];
        `RSEM_TRACE_CTRL: begin
          trace_processor_access_q <= reg_wdata_i[`RSEM_ACC_BIT];
          trace_pointer_reset_q <= reg_wdata_i[`RSEM_PRST_BIT];
        end
        `RSEM_INT_EN: int_en_q <= reg_wdata_i[2:0];
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Expected trace string
  // --------------------------------------------------------------------------
  logic [`RSEM_TRACE_PTR_W-1:0] trace_ptr_q;
  logic [7:0] trace_mem_q [`RSEM_TRACE_LEN];
  logic ptr_rewind, ptr_step;

  assign ptr_rewind = wr_ctrl && reg_wdata_i[`RSEM_PRST_BIT] && !trace_pointer_reset_q;
  assign ptr_step = trace_processor_access_q ? (wr_data || rd_data) : trace_step_i;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      trace_ptr_q <= '0;
    end else if (ptr_rewind) begin
      trace_ptr_q <= '0;
    end else if (ptr_step) begin
      trace_ptr_q <= trace_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < `RSEM_TRACE_LEN; i++) begin
        trace_mem_q[i] <= 8'h00;
      end
    end else if (wr_data && trace_processor_access_q) begin
      trace_mem_q[trace_ptr_q] <= reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      trace_string_byte_o <= 8'h00;
    end else begin
      trace_string_byte_o <= trace_mem_q[trace_ptr_q];
    end
  end

  // --------------------------------------------------------------------------
  // Error counters
  // --------------------------------------------------------------------------
  logic [15:0] b1_cnt_q, b1_buf_q, b1_inc;
  logic [12:0] b2_cnt_q, b2_buf_q;

  assign b1_inc = parity_count_unit_select_q ? {15'h0000, b1_blk_err_i}
                : (b1_bit_err_i ? {12'h000, b1_bit_err_cnt_i} : 16'h0000);

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      b1_cnt_q <= 16'h0000;
      b1_buf_q <= 16'h0000;
    end else if (wr_b1hi) begin
      b1_buf_q <= b1_cnt_q;
      b1_cnt_q <= b1_inc;
    end else begin
      b1_cnt_q <= b1_cnt_q + b1_inc;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      b2_cnt_q <= 13'h0000;
      b2_buf_q <= 13'h0000;
    end else if (wr_b2hi) begin
      b2_buf_q <= b2_cnt_q;
      b2_cnt_q <= {12'h000, b2_blk_err_i};
    end else if (b2_blk_err_i) begin
      b2_cnt_q <= b2_cnt_q + 13'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // Excessive B2 window detector
  // --------------------------------------------------------------------------
  rsem_state_type state_q;
  logic [13:0] frame_cnt_q, win_frames;
  logic [7:0] win_err_q;
  logic [6:0] run_q, run_target;
  logic win_end, win_bad, win_clean, win_hit, flip;

  assign win_frames = state_q == RSEM_HUNT_CLR
                    ? {clear_window_length_q, 3'h7} : {set_window_length_q, 3'h7};
  assign win_end = frame_pulse_i && (frame_cnt_q == win_frames);
  assign win_bad = (errored_window_threshold_q == 8'h00) || (win_err_q >= errored_window_threshold_q);
  assign win_clean = (clean_window_threshold_q == 8'h00) || (win_err_q <= clean_window_threshold_q);
  assign win_hit = state_q == RSEM_HUNT_CLR ? win_clean : win_bad;
  assign run_target = state_q == RSEM_HUNT_CLR ? clear_window_run_q : set_window_run_q;
  assign flip = win_end && win_hit && (run_target != 7'h00) && (run_q + 7'h01 >= run_target);

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state_q <= RSEM_HUNT_SET;
    end else if (flip) begin
      case (state_q)
        RSEM_HUNT_SET: state_q <= RSEM_HUNT_CLR;
        RSEM_HUNT_CLR: state_q <= RSEM_HUNT_SET;
        default: state_q <= RSEM_HUNT_SET;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || flip) begin
      frame_cnt_q <= 14'h0000;
      win_err_q <= 8'h00;
      run_q <= 7'h00;
    end else begin
      if (win_end) begin
        frame_cnt_q <= 14'h0000;
        win_err_q <= {7'h00, b2_blk_err_i};
        run_q <= win_hit ? run_q + 7'h01 : 7'h00;
      end else begin
        if (frame_pulse_i) begin
          frame_cnt_q <= frame_cnt_q + 14'h0001;
        end
        if (b2_blk_err_i && win_err_q != 8'hFF) begin
          win_err_q <= win_err_q + 8'h01;
        end
      end
    end
  end

  assign excessive_mux_error_status_o = (state_q == RSEM_HUNT_CLR);

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  logic [2:0] int_stat_q, int_evt, int_clr;
  assign int_evt = {flip && state_q == RSEM_HUNT_CLR, flip && state_q == RSEM_HUNT_SET, b2_blk_err_i};
  assign int_clr = (reg_wr_i && reg_addr_i == `RSEM_INT_CLR) ? reg_wdata_i[2:0] : 3'h0;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      int_stat_q <= 3'h0;
    end else begin
      int_stat_q <= (int_stat_q & ~int_clr) | int_evt;
    end
  end

  assign irq_o = |(int_stat_q & int_en_q);

  // --------------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `RSEM_TRACE_DATA: reg_rdata_o <= trace_mem_q[trace_ptr_q];
        `RSEM_B1_LO: reg_rdata_o <= b1_buf_q[7:0];
        `RSEM_B1_HI: reg_rdata_o <= b1_buf_q[15:8];
        `RSEM_B2BLK_LO: reg_rdata_o <= b2_buf_q[7:0];
        `RSEM_B2BLK_HI: reg_rdata_o <= {3'h0, b2_buf_q[12:8]};
        `RSEM_SETWIN_LO: reg_rdata_o <= set_window_length_q[7:0];
        `RSEM_SETWIN_HI: reg_rdata_o <= {5'h00, set_window_length_q[10:8]};
        `RSEM_CLRWIN_LO: reg_rdata_o <= clear_window_length_q[7:0];
        `RSEM_CLRWIN_HI: reg_rdata_o <= {5'h00, clear_window_length_q[10:8]};
        `RSEM_SETRUN: reg_rdata_o <= {1'b0, set_window_run_q};
        `RSEM_CLRRUN: reg_rdata_o <= {1'b0, clear_window_run_q};
        `RSEM_ERRMIN: reg_rdata_o <= errored_window_threshold_q;
        `RSEM_CLEANMAX: reg_rdata_o <= clean_window_threshold_q;
        `RSEM_B1_CFG: reg_rdata_o <= {7'h00, parity_count_unit_select_q};
        `RSEM_STATUS: reg_rdata_o <= {7'h00, excessive_mux_error_status_o};
        `RSEM_INT_STAT: reg_rdata_o <= {5'h00, int_stat_q};
        `RSEM_INT_EN: reg_rdata_o <= {5'h00, int_en_q};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  a_b1_block_count: assert property (
    parity_count_unit_select_q && !wr_b1hi && b1_blk_err_i |=> b1_cnt_q == $past(b1_cnt_q) + 16'h0001)
    else $error("B1 counter did not advance on block error.");
  a_b1_snapshot: assert property (
    wr_b1hi |=> b1_buf_q == $past(b1_cnt_q) && b1_cnt_q == $past(b1_inc))
    else $error("B1 snapshot wrong.");
  a_b1_read_hi: assert property (
    reg_rd_i && reg_addr_i == `RSEM_B1_HI |=> reg_rdata_o == b1_buf_q[15:8])
    else $error("B1 upper byte read wrong.");
  a_b2_snapshot: assert property (
    wr_b2hi && !b2_blk_err_i |=> b2_cnt_q == 13'h0000 && b2_buf_q == $past(b2_cnt_q))
    else $error("B2 snapshot wrong.");
  a_b2_count: assert property (
    !wr_b2hi && b2_blk_err_i |=> b2_cnt_q == $past(b2_cnt_q) + 13'h0001)
    else $error("B2 counter did not advance.");
  a_ptr_rewind: assert property (
    ptr_rewind |=> trace_ptr_q == 4'h0)
    else $error("Trace pointer not rewound.");
  a_ptr_proc_step: assert property (
    trace_processor_access_q && !ptr_rewind && (wr_data || rd_data) |=> trace_ptr_q == $past(trace_ptr_q) + 4'h1)
    else $error("Trace pointer did not step on access.");
  a_ptr_hw_hold: assert property (
    trace_processor_access_q && !ptr_rewind && !wr_data && !rd_data |=> $stable(trace_ptr_q))
    else $error("Trace pointer moved outside processor access.");
  a_no_set_zero: assert property (
    state_q == RSEM_HUNT_SET && set_window_run_q == 7'h00 |=> state_q == RSEM_HUNT_SET)
    else $error("Status set with zero run.");
  a_no_clr_zero: assert property (
    state_q == RSEM_HUNT_CLR && clear_window_run_q == 7'h00 |=> state_q == RSEM_HUNT_CLR)
    else $error("Status cleared with zero run.");
  a_win_restart: assert property (
    flip |=> frame_cnt_q == 14'h0000 && run_q == 7'h00)
    else $error("Window not restarted on status change.");
  a_irq_set_wins: assert property (
    |int_evt |=> (int_stat_q & $past(int_evt)) == $past(int_evt))
    else $error("Interrupt event lost against a clear.");
  a_irq_clear: assert property (
    |int_clr && int_evt == 3'h0 |=> (int_stat_q & $past(int_clr)) == 3'h0)
    else $error("Interrupt status bit not cleared.");

  a_trace_ctrl_wo: assert property (
    reg_rd_i && reg_addr_i == `RSEM_TRACE_CTRL |=> reg_rdata_o == 8'h00)
    else $error("Write-only trace control read back non-zero.");
  a_b1_bit_count: assert property (
    !parity_count_unit_select_q && !wr_b1hi && b1_bit_err_i |=>
      b1_cnt_q == $past(b1_cnt_q) + {12'h000, $past(b1_bit_err_cnt_i)})
    else $error("B1 counter did not add bit errors.");
  a_b1_unit_ignore: assert property (
    parity_count_unit_select_q && !wr_b1hi && !b1_blk_err_i |=> $stable(b1_cnt_q))
    else $error("B1 counter moved without a block error.");
  a_b2_hold: assert property (
    !wr_b2hi && !b2_blk_err_i |=> $stable(b2_cnt_q))
    else $error("B2 counter moved without an event.");
  a_b2_snap_event: assert property (
    wr_b2hi && b2_blk_err_i |=> b2_cnt_q == 13'h0001)
    else $error("B2 event beside snapshot lost.");
  a_b2_read_hi: assert property (
    reg_rd_i && reg_addr_i == `RSEM_B2BLK_HI |=> reg_rdata_o == {3'h0, b2_buf_q[12:8]})
    else $error("B2 upper byte read wrong.");
  a_b1_read_lo: assert property (
    reg_rd_i && reg_addr_i == `RSEM_B1_LO |=> reg_rdata_o == b1_buf_q[7:0])
    else $error("B1 lower byte read wrong.");
  a_ptr_hw_step: assert property (
    !trace_processor_access_q && !ptr_rewind && trace_step_i |=> trace_ptr_q == $past(trace_ptr_q) + 4'h1)
    else $error("Trace pointer did not follow the comparator.");
  a_trace_store: assert property (
    wr_data && trace_processor_access_q |=> trace_mem_q[$past(trace_ptr_q)] == $past(reg_wdata_i))
    else $error("Trace byte not stored at the pointer.");
  a_win_frame_step: assert property (
    frame_pulse_i && !win_end && !flip |=> frame_cnt_q == $past(frame_cnt_q) + 14'h0001)
    else $error("Window frame count did not step.");
  a_win_end_zero: assert property (
    win_end |=> frame_cnt_q == 14'h0000)
    else $error("Window frame count not restarted at window end.");
  a_win_err_restart: assert property (
    win_end && !flip |=> win_err_q == {7'h00, $past(b2_blk_err_i)})
    else $error("Window error count not restarted.");
  a_run_break: assert property (
    win_end && !win_hit |=> run_q == 7'h00)
    else $error("Window run not broken by a miss.");
  a_status_hold: assert property (
    !flip |=> $stable(state_q))
    else $error("Status changed without a completed run.");
  a_rdata_idle: assert property (
    !reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("Read data not zero outside a read.");

  c_status_set: cover property (state_q == RSEM_HUNT_SET ##1 state_q == RSEM_HUNT_CLR);
  c_status_clr: cover property (state_q == RSEM_HUNT_CLR ##1 state_q == RSEM_HUNT_SET);
  c_b1_snap: cover property (wr_b1hi ##1 reg_rd_i && reg_addr_i == `RSEM_B1_LO);
  c_trace_write: cover property (ptr_rewind ##1 wr_data ##1 wr_data);
  c_b2_snap: cover property (wr_b2hi ##1 reg_rd_i && reg_addr_i == `RSEM_B2BLK_LO);

endmodule

// File: include/rsem_regs.svh
// Register offsets, field positions and reset values of the receive section error monitor.
// Assumes an 8-bit register port with byte addresses.
`ifndef RSEM_REGS_SVH
`define RSEM_REGS_SVH

`define RSEM_ADDR_W 8
`define RSEM_TRACE_CTRL 8'h0E
`define RSEM_TRACE_DATA 8'h0F
`define RSEM_B2BLK_LO 8'h10
`define RSEM_B2BLK_HI 8'h11
`define RSEM_CLRWIN_LO 8'h15
`define RSEM_CLRWIN_HI 8'h16
`define RSEM_CLRRUN 8'h17
`define RSEM_CLEANMAX 8'h18
`define RSEM_SETWIN_LO 8'h1B
`define RSEM_SETWIN_HI 8'h1C
`define RSEM_SETRUN 8'h1D
`define RSEM_ERRMIN 8'h1E
`define RSEM_B1_LO 8'h45
`define RSEM_B1_HI 8'h46
`define RSEM_B1_CFG 8'h47
`define RSEM_STATUS 8'h50
`define RSEM_INT_STAT 8'h51
`define RSEM_INT_CLR 8'h52
`define RSEM_INT_EN 8'h53

`define RSEM_ACC_BIT 1
`define RSEM_PRST_BIT 0
`define RSEM_CLRRUN_RST 7'h07
`define RSEM_SETRUN_RST 7'h03
`define RSEM_CLEANMAX_RST 8'h08
`define RSEM_ERRMIN_RST 8'h2B
`define RSEM_WIN_MULT 3
`define RSEM_TRACE_LEN 16
`define RSEM_TRACE_PTR_W 4

`endif

// File: include/rsem_pkg.sv
// Types of the receive section error monitor.
// Assumes nothing of its surroundings.
package rsem_pkg;
  typedef enum logic [1:0] {
    RSEM_HUNT_SET = 2'b01,
    RSEM_HUNT_CLR = 2'b10
  } rsem_state_type;
endpackage

// File: test/rsem_monitor_tb_top.sv
// Self-checking bench of the receive section error monitor.
// Assumes the byte-wide register port with read data one cycle after the strobe and one 250 MHz clock.
`timescale 1ns/1ps
`include "rsem_regs.svh"

module rsem_monitor_tb_top;
  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  logic sys_clk_i, rstn_i, reg_wr_i, reg_rd_i, frame_pulse_i, b1_bit_err_i, b1_blk_err_i, b2_blk_err_i;
  logic trace_step_i, excessive_mux_error_status_o, irq_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, trace_string_byte_o;
  logic [3:0] b1_bit_err_cnt_i;
  int err_count = 0;
  int cmp_count = 0;
  int b1_m = 0, b2_m = 0, fc = 0, ec = 0, run = 0, st = 0;
  int setlen, setrun, errmin, clrlen, clrrun, cmax;
  logic [7:0] tr [16];
  logic [7:0] ra [17] = '{8'h17, 8'h18, 8'h1D, 8'h1E, 8'h15, 8'h16, 8'h1B, 8'h1C, 8'h0E, 8'h0F, 8'h10, 8'h11,
                          8'h45, 8'h46, 8'h50, 8'h51, 8'h30};
  logic [7:0] rv [17] = '{8'h07, 8'h08, 8'h03, 8'h2B, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                          8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  rsem_monitor i_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .frame_pulse_i(frame_pulse_i), .b1_bit_err_i(b1_bit_err_i), .b1_bit_err_cnt_i(b1_bit_err_cnt_i),
    .b1_blk_err_i(b1_blk_err_i), .b2_blk_err_i(b2_blk_err_i), .trace_step_i(trace_step_i),
    .trace_string_byte_o(trace_string_byte_o),
    .excessive_mux_error_status_o(excessive_mux_error_status_o), .irq_o(irq_o));

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic final_report;
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    chk(16'(reg_rdata_o), 16'(e));
  endtask

  // Snapshot write to the upper byte, optionally with a B1 event in the same cycle.
  task automatic snap(input logic [7:0] hi, input logic [7:0] lo, ref int m, input int ev);
    int old;
    old = m;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= hi;
    reg_wdata_i <= 8'hA5;
    b1_bit_err_i <= 1'(ev);
    b1_bit_err_cnt_i <= 4'h5;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    b1_bit_err_i <= 1'b0;
    m = ev * 5;
    rdchk(lo, old[7:0]);
    rdchk(hi, old[15:8]);
  endtask

  task automatic events(input int n, input int mode);
    logic e1, e2, e3;
    logic [3:0] c;
    repeat (n) begin
      e1 = 1'($urandom_range(0, 1));
      e2 = 1'($urandom_range(0, 1));
      e3 = 1'($urandom_range(0, 1));
      c = 4'($urandom_range(1, 15));
      @(posedge sys_clk_i);
      b1_bit_err_i <= e1;
      b1_bit_err_cnt_i <= c;
      b1_blk_err_i <= e2;
      b2_blk_err_i <= e3;
      b1_m = (b1_m + ((mode == 0) ? (e1 ? int'(c) : 0) : int'(e2))) & 32'hFFFF;
      b2_m = (b2_m + int'(e3)) & 32'h1FFF;
    end
    @(posedge sys_clk_i);
    b1_bit_err_i <= 1'b0;
    b1_blk_err_i <= 1'b0;
    b2_blk_err_i <= 1'b0;
  endtask

  task automatic cfg(input int sl, input int sr, input int em, input int cl, input int cr, input int cm);
    logic [7:0] a [6] = '{8'h1B, 8'h1D, 8'h1E, 8'h15, 8'h17, 8'h18};
    logic [7:0] v [6];
    v = '{8'(sl), 8'(sr), 8'(em), 8'(cl), 8'(cr), 8'(cm)};
    setlen = sl;
    setrun = sr;
    errmin = em;
    clrlen = cl;
    clrrun = cr;
    cmax = cm;
    for (int i = 0; i < 6; i++) begin
      wr(a[i], v[i]);
      rdchk(a[i], v[i]);
    end
  endtask

  // One frame carrying n B2 block errors, then the window model and a status compare.
  task automatic frame(input int n);
    int hit, tgt;
    repeat (n) begin
      @(posedge sys_clk_i);
      b2_blk_err_i <= 1'b1;
    end
    @(posedge sys_clk_i);
    b2_blk_err_i <= 1'b0;
    frame_pulse_i <= 1'b1;
    @(posedge sys_clk_i);
    frame_pulse_i <= 1'b0;
    b2_m = (b2_m + n) & 32'h1FFF;
    ec += n;
    fc++;
    if (fc == 8 * ((st != 0 ? clrlen : setlen) + 1)) begin
      hit = (st != 0) ? int'(cmax == 0 || ec <= cmax) : int'(ec >= errmin);
      tgt = (st != 0) ? clrrun : setrun;
      run = (hit != 0) ? run + 1 : 0;
      if (hit != 0 && tgt != 0 && run >= tgt) begin
        st = 1 - st;
        run = 0;
      end
      fc = 0;
      ec = 0;
    end
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk(16'(excessive_mux_error_status_o), 16'(st));
  endtask

  task automatic win(input int n);
    frame(n);
    for (int i = 0; i < 20 && fc != 0; i++) frame(0);
  endtask

  task automatic step_chk(input logic [7:0] e);
    @(posedge sys_clk_i);
    trace_step_i <= 1'b1;
    @(posedge sys_clk_i);
    trace_step_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk(16'(trace_string_byte_o), 16'(e));
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    err_count++;
    final_report();
  end

  initial begin
    {rstn_i, reg_wr_i, reg_rd_i, frame_pulse_i, b1_bit_err_i, b1_blk_err_i, b2_blk_err_i, trace_step_i} = '0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    b1_bit_err_cnt_i = 4'h0;
    void'($urandom(70696));
    repeat (10) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 17; i++) rdchk(ra[i], rv[i]);
    wr(`RSEM_INT_EN, 8'h07);
    // Expected trace: program, rewind, verify, then hand the pointer to the comparator.
    wr(`RSEM_TRACE_CTRL, 8'h02);
    wr(`RSEM_TRACE_CTRL, 8'h03);
    for (int i = 0; i < 16; i++) begin
      tr[i] = 8'($urandom);
      wr(`RSEM_TRACE_DATA, tr[i]);
    end
    wr(`RSEM_TRACE_CTRL, 8'h02);
    wr(`RSEM_TRACE_CTRL, 8'h03);
    step_chk(tr[0]);
    for (int i = 0; i < 3; i++) rdchk(`RSEM_TRACE_DATA, tr[i]);
    wr(`RSEM_TRACE_CTRL, 8'h03);
    rdchk(`RSEM_TRACE_DATA, tr[3]);
    rdchk(`RSEM_TRACE_CTRL, 8'h00);
    wr(`RSEM_TRACE_CTRL, 8'h02);
    wr(`RSEM_TRACE_CTRL, 8'h03);
    wr(`RSEM_TRACE_CTRL, 8'h01);
    rdchk(`RSEM_TRACE_DATA, tr[0]);
    rdchk(`RSEM_TRACE_DATA, tr[0]);
    for (int i = 1; i <= 17; i++) step_chk(tr[i % 16]);
    // Excessive B2 window detector: directed, random, then zero thresholds and counts.
    cfg(0, 2, 3, 0, 2, 1);
    win(3);
    win(2);
    win(4);
    win(3);
    win(2);
    win(1);
    win(0);
    repeat (6) win($urandom_range(0, 4));
    cfg(1, 0, 0, 0, 0, 0);
    repeat (3) win($urandom_range(0, 3));
    cfg(1, 1, 0, 0, 1, 0);
    repeat (3) win($urandom_range(5, 9));
    rdchk(`RSEM_STATUS, 8'(st));
    // Error counters in both B1 units, with an event beside the snapshot write.
    wr(`RSEM_B1_CFG, 8'h00);
    events(40, 0);
    snap(`RSEM_B1_HI, `RSEM_B1_LO, b1_m, 1);
    events(20, 0);
    snap(`RSEM_B1_HI, `RSEM_B1_LO, b1_m, 0);
    wr(`RSEM_B1_CFG, 8'h01);
    events(40, 1);
    snap(`RSEM_B1_HI, `RSEM_B1_LO, b1_m, 0);
    snap(`RSEM_B2BLK_HI, `RSEM_B2BLK_LO, b2_m, 0);
    // Interrupts: raised, cleared, raised again, masked.
    rdchk(`RSEM_INT_STAT, 8'h07);
    chk(16'(irq_o), 16'h0001);
    wr(`RSEM_INT_CLR, 8'h07);
    rdchk(`RSEM_INT_STAT, 8'h00);
    chk(16'(irq_o), 16'h0000);
    events(1, 1);
    frame(1);
    rdchk(`RSEM_INT_STAT, 8'h01);
    chk(16'(irq_o), 16'h0001);
    wr(`RSEM_INT_EN, 8'h00);
    @(negedge sys_clk_i);
    chk(16'(irq_o), 16'h0000);
    final_report();
  end
endmodule
